// [rtl/pmc_pkg.sv]
/*
  power mode controller package: register offsets, field positions,
  reset values and cycle counts shared by the controller.
  assumes a 32-bit apb register bus and one system clock.
*/
package pmc_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] PMC_OFF_GATE2 = 8'h00;
  localparam logic [7:0] PMC_OFF_MODE_CTL = 8'h04;
  localparam logic [7:0] PMC_OFF_STATUS = 8'h08;

  // ==========================================================
  // peripheral gate register two: fields and reset value
  localparam int PMC_GATE_SERIAL_TWO = 7;
  localparam int PMC_GATE_INTERVAL = 4;
  localparam int PMC_GATE_MULTI = 1;
  localparam int PMC_GATE_PWM = 0;
  localparam logic [7:0] PMC_GATE_WMASK = 8'h93;
  localparam logic [7:0] PMC_GATE_RESET = 8'h00;

  // ==========================================================
  // mode control register fields
  localparam int PMC_CTL_DIRECT = 0;
  localparam int PMC_CTL_STANDBY = 1;
  localparam int PMC_CTL_SUBSLEEP = 2;
  localparam int PMC_CTL_LOWSPEED = 3;
  localparam int PMC_CTL_WAIT_LSB = 4;
  localparam int PMC_CTL_RTC_TB = 8;
  localparam int PMC_CTL_WDT_INTOSC = 9;
  localparam int PMC_CTL_MT_SYSCLK = 10;
  localparam logic [10:0] PMC_CTL_RESET = 11'h000;

  // ==========================================================
  // cycle counts
  localparam int PMC_WAIT_SHIFT = 4;
  localparam int PMC_SUB_DIV = 16;

  // operating modes
  typedef enum logic [2:0] {
    PMC_RESET, PMC_HS_RUN, PMC_LS_RUN, PMC_SLEEP,
    PMC_SUBSLEEP, PMC_STANDBY, PMC_WAKE_WAIT
  } pmc_mode_e;
endpackage : pmc_pkg

// [rtl/pmc_power_mode_controller.sv]
/*
  power mode controller: peripheral gating register two and the
  sleep-instruction mode sequencer with interrupt wake-up.
  assumes an apb master on pclk, a cpu that pulses sleep_exec and
  an interrupt unit that reports an enabled pending request.
*/
// What this block does
// [RULE_01] gate bit 7 stops second serial unit
// [RULE_02] gate bit 4 stops interval timer
// [RULE_03] gate bit 1 stops multi-function timer
// [RULE_04] gate bit 0 stops pulse-width unit
// [RULE_05] reserved gate bits read zero, reset zero
// [RULE_06] sleep instruction halts program unless direct; code also halts (subsleep) on direct with subsleep 1, low-speed 0
// [RULE_07] accepted interrupt resumes program execution
// [RULE_08] external reset forces the reset state
// [RULE_09] non-direct sleep picks sleep, subsleep, standby
// [RULE_10] direct with low-speed 0 goes high-speed; code enters subsleep instead when the subsleep bit is 1
// [RULE_11] direct with low-speed 1 goes low-speed
// [RULE_12] run modes switch without halting
// [RULE_13] same run mode reentry without halting
// [RULE_14] subsleep-select transition resets four units
// [RULE_15] clock runs in low power if timebase
// [RULE_16] watchdog holds unless internal oscillator
// [RULE_17] multi timer counts subclock in low power
// [RULE_18] main oscillator off in low power modes
// [RULE_19] four units held reset in low power
// [RULE_20] masked or disabled interrupt does not wake
// [RULE_21] standby wake waits selected oscillator period
// [RULE_22] clearing gate bit restores the module clock
// [RULE_23] standby puts port outputs high impedance
`timescale 1ns/1ps
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int SUB_DIV = PMC_SUB_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external reset pin and cpu side
  input wire logic res_pin_n,
  input wire logic sleep_exec,
  input wire logic irq_pending,
  input wire logic cpu_imask,
  output logic cpu_halt,
  output logic low_speed_run,
  output logic direct_done,
  // peripheral clock enables
  output logic serial_two_clk_en,
  output logic interval_clk_en,
  output logic multi_timer_clk_en,
  output logic pulse_width_clk_en,
  // peripheral resets and retention
  output logic cmp_timer_rst,
  output logic serial_one_rst,
  output logic serial_two_rst,
  output logic converter_rst,
  output logic rtc_run,
  output logic wdt_run,
  output logic multi_timer_sub_tick,
  // oscillators and ports
  output logic ext_osc_en,
  output logic sub_osc_en,
  output logic port_hiz,
  output logic chip_reset
);

  // ==========================================================
  // declarations
  logic [7:0] gate_ff; // peripheral gate register two
  logic [10:0] ctl_ff; // mode control register
  logic [31:0] rdata_ff; // read data latched in setup
  pmc_mode_e mode_ff; // current operating mode
  pmc_mode_e nxt_mode;
  logic wake_ls_ff; // wake target is low-speed run
  logic [7:0] wait_ff; // standby wake wait counter
  logic unit_rst_ff; // one-cycle unit reset pulse
  logic direct_ff; // direct switch done pulse
  logic res_meta_ff; // reset pin first stage
  logic res_sync_ff; // reset pin second stage
  logic [7:0] div_ff; // subclock divider
  logic sub_tick; // subclock rate enable
  logic ext_rst; // synchronised reset pin asserted
  logic wake_ok; // interrupt accepted for wake-up
  logic run_mode; // program executing
  logic low_power; // low-speed, subsleep or standby
  logic wr_en; // apb write access phase
  logic setup; // apb setup phase
  logic mapped; // address hits a register
  logic sleep_go; // sleep taken in a run mode

  // ==========================================================
  // helpers
  // cycles of oscillator wait for a wait select code
  function automatic logic [7:0] wait_cycles(input logic [2:0] sel);
    wait_cycles = ({5'h00, sel} + 8'h01) << PMC_WAIT_SHIFT;
  endfunction : wait_cycles

  // address decode
  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == PMC_OFF_GATE2) || (a == PMC_OFF_MODE_CTL) ||
             (a == PMC_OFF_STATUS);
  endfunction : is_reg

  // ==========================================================
  // apb access decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign mapped = is_reg(paddr);
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_ff;
  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (paddr)
        PMC_OFF_GATE2: rdata_ff <= {24'h000000, gate_ff}; // RULE_05
        PMC_OFF_MODE_CTL: rdata_ff <= {21'h000000, ctl_ff};
        PMC_OFF_STATUS: rdata_ff <= {28'h0000000, low_speed_run,
                                     mode_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end
  // gate register: reserved bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ff <= PMC_GATE_RESET; // RULE_05
    end else if (ext_rst) begin
      gate_ff <= PMC_GATE_RESET;
    end else if (wr_en && paddr == PMC_OFF_GATE2) begin
      gate_ff <= pwdata[7:0] & PMC_GATE_WMASK; // RULE_05
    end
  end
  // mode control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= PMC_CTL_RESET;
    end else if (ext_rst) begin
      ctl_ff <= PMC_CTL_RESET;
    end else if (wr_en && paddr == PMC_OFF_MODE_CTL) begin
      ctl_ff <= pwdata[10:0];
    end
  end

  // ==========================================================
  // reset pin synchroniser and subclock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_meta_ff <= 1'b1;
      res_sync_ff <= 1'b1;
    end else begin
      res_meta_ff <= res_pin_n;
      res_sync_ff <= res_meta_ff;
    end
  end
  assign ext_rst = !res_sync_ff;
  // divider makes the subclock rate enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h00;
    end else if (div_ff == 8'(SUB_DIV - 1)) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end
  assign sub_tick = (div_ff == 8'(SUB_DIV - 1));

  // ==========================================================
  // mode sequencer
  assign wake_ok = irq_pending && !cpu_imask; // RULE_20
  assign run_mode = (mode_ff == PMC_HS_RUN) || (mode_ff == PMC_LS_RUN);
  assign sleep_go = run_mode && sleep_exec;
  // next mode selection
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      PMC_RESET: begin
        nxt_mode = PMC_HS_RUN;
      end
      PMC_HS_RUN, PMC_LS_RUN: begin
        if (sleep_exec) begin
          if (ctl_ff[PMC_CTL_DIRECT] && ctl_ff[PMC_CTL_LOWSPEED]) begin
            nxt_mode = PMC_LS_RUN; // RULE_11 RULE_12 RULE_13
          end else if (ctl_ff[PMC_CTL_DIRECT] &&
                       !ctl_ff[PMC_CTL_SUBSLEEP]) begin
            nxt_mode = PMC_HS_RUN; // RULE_10 RULE_12 RULE_13
          end else if (ctl_ff[PMC_CTL_STANDBY] &&
                       !ctl_ff[PMC_CTL_DIRECT]) begin
            nxt_mode = PMC_STANDBY; // RULE_06 RULE_09
          end else if (ctl_ff[PMC_CTL_SUBSLEEP]) begin
            nxt_mode = PMC_SUBSLEEP; // RULE_06 RULE_09
          end else begin
            nxt_mode = PMC_SLEEP; // RULE_06 RULE_09
          end
        end
      end
      PMC_SLEEP, PMC_SUBSLEEP: begin
        if (wake_ok) begin
          nxt_mode = wake_ls_ff ? PMC_LS_RUN : PMC_HS_RUN; // RULE_07
        end
      end
      PMC_STANDBY: begin
        if (wake_ok) begin
          nxt_mode = PMC_WAKE_WAIT; // RULE_21
        end
      end
      PMC_WAKE_WAIT: begin
        if (wait_ff == 8'h01) begin
          nxt_mode = PMC_HS_RUN; // RULE_07 RULE_21
        end
      end
      default: begin
        nxt_mode = PMC_RESET;
      end
    endcase
    if (ext_rst) begin
      nxt_mode = PMC_RESET; // RULE_08
    end
  end
  // mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= PMC_RESET;
    end else begin
      mode_ff <= nxt_mode;
    end
  end
  // wake target latched when halting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ls_ff <= 1'b0;
    end else if (sleep_go) begin
      wake_ls_ff <= ctl_ff[PMC_CTL_LOWSPEED]; // RULE_09
    end
  end
  // oscillator wait counter on standby wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 8'h00;
    end else if (mode_ff == PMC_STANDBY && wake_ok) begin
      wait_ff <= wait_cycles(ctl_ff[PMC_CTL_WAIT_LSB +: 3]); // RULE_21
    end else if (mode_ff == PMC_WAKE_WAIT && wait_ff != 8'h00) begin
      wait_ff <= wait_ff - 8'h01;
    end
  end
  // unit reset pulse on transitions with subsleep select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_rst_ff <= 1'b0;
    end else begin
      unit_rst_ff <= sleep_go && ctl_ff[PMC_CTL_SUBSLEEP]; // RULE_14
    end
  end
  // direct switch completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_ff <= 1'b0;
    end else begin
      direct_ff <= sleep_go && (nxt_mode == PMC_HS_RUN ||
                                nxt_mode == PMC_LS_RUN);
    end
  end

  // ==========================================================
  // mode dependent outputs
  assign low_power = (mode_ff == PMC_LS_RUN) ||
                     (mode_ff == PMC_SUBSLEEP) ||
                     (mode_ff == PMC_STANDBY);
  assign cpu_halt = !run_mode;
  assign low_speed_run = (mode_ff == PMC_LS_RUN);
  assign direct_done = direct_ff;
  assign chip_reset = (mode_ff == PMC_RESET);
  // module gating from the gate register
  assign serial_two_clk_en = !gate_ff[PMC_GATE_SERIAL_TWO]; // RULE_01 RULE_22
  assign interval_clk_en = !gate_ff[PMC_GATE_INTERVAL]; // RULE_02 RULE_22
  assign multi_timer_clk_en = !gate_ff[PMC_GATE_MULTI]; // RULE_03 RULE_22
  assign pulse_width_clk_en = !gate_ff[PMC_GATE_PWM]; // RULE_04 RULE_22
  // unit resets: held in low power, pulsed on transitions
  assign cmp_timer_rst = low_power || unit_rst_ff || chip_reset; // RULE_19
  assign serial_one_rst = low_power || unit_rst_ff || chip_reset; // RULE_19
  assign serial_two_rst = low_power || unit_rst_ff || chip_reset
                          || gate_ff[PMC_GATE_SERIAL_TWO]; // RULE_01
  assign converter_rst = low_power || unit_rst_ff || chip_reset; // RULE_14
  // retention controls
  assign rtc_run = !low_power || ctl_ff[PMC_CTL_RTC_TB]; // RULE_15
  assign wdt_run = !low_power || ctl_ff[PMC_CTL_WDT_INTOSC]; // RULE_16
  assign multi_timer_sub_tick = low_power && sub_tick &&
                                ctl_ff[PMC_CTL_MT_SYSCLK]; // RULE_17
  // oscillators and port drive
  assign ext_osc_en = !low_power; // RULE_18 RULE_21
  assign sub_osc_en = 1'b1; // RULE_18
  assign port_hiz = (mode_ff == PMC_STANDBY); // RULE_23

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // standby wake with wait select one: 32 wait cycles, then run
  sequence s_standby_wake;
    mode_ff == PMC_STANDBY && wake_ok && !ext_rst &&
    ctl_ff[PMC_CTL_WAIT_LSB +: 3] == 3'h1;
  endsequence
  // oscillator on for the first 8 wait cycles, high-speed run after the wait
  sequence s_wait_then_run;
    (mode_ff == PMC_WAKE_WAIT && ext_osc_en)[*8] ##25
    mode_ff == PMC_HS_RUN;
  endsequence
  chk_gate_write_stop: assert property ( // RULE_01
    wr_en && paddr == PMC_OFF_GATE2 && pwdata[7] && !ext_rst
    |=> !serial_two_clk_en && serial_two_rst)
    else $error("serial unit two not stopped after gate write");
  chk_gate_clear_run: assert property ( // RULE_22
    wr_en && paddr == PMC_OFF_GATE2 && !pwdata[0]
    |=> pulse_width_clk_en)
    else $error("pulse width clock not restored after clear");
  chk_reserved_zero: assert property ( // RULE_05
    $past(setup && !pwrite && paddr == PMC_OFF_GATE2)
    |-> prdata[6:5] == 2'b00 && prdata[3:2] == 2'b00)
    else $error("reserved gate bits read as nonzero");
  chk_sleep_entry: assert property ( // RULE_09
    sleep_go && !ext_rst && ctl_ff[3:0] == 4'h0
    |=> mode_ff == PMC_SLEEP && cpu_halt)
    else $error("sleep instruction did not enter sleep");
  chk_masked_hold: assert property ( // RULE_20
    mode_ff == PMC_SLEEP && cpu_imask && !ext_rst
    |=> mode_ff == PMC_SLEEP)
    else $error("masked interrupt left sleep mode");
  chk_wake_resume: assert property ( // RULE_07
    mode_ff == PMC_SUBSLEEP && wake_ok && !ext_rst
    |=> !cpu_halt && low_speed_run == $past(wake_ls_ff))
    else $error("accepted interrupt did not resume execution");
  chk_ext_reset: assert property ( // RULE_08
    ext_rst |=> chip_reset && cpu_halt)
    else $error("external reset did not force reset state");
  chk_direct_low: assert property ( // RULE_11
    sleep_go && !ext_rst && ctl_ff[PMC_CTL_DIRECT] &&
    ctl_ff[PMC_CTL_LOWSPEED]
    |=> low_speed_run && !cpu_halt && direct_done)
    else $error("direct switch to low-speed run failed");
  chk_subsleep_units: assert property ( // RULE_14
    sleep_go && ctl_ff[PMC_CTL_SUBSLEEP]
    |=> converter_rst && serial_one_rst && cmp_timer_rst)
    else $error("units not reset on subsleep transition");
  chk_standby_ports: assert property ( // RULE_23
    mode_ff == PMC_STANDBY |-> port_hiz && !ext_osc_en)
    else $error("standby without port high impedance");
  chk_wake_wait: assert property ( // RULE_21
    s_standby_wake |=> s_wait_then_run)
    else $error("standby wake wait length wrong");

endmodule : pmc_power_mode_controller

// [test/pmc_cpu_model.sv]
/*
  cpu and interrupt side model for the power mode controller:
  sleep instruction pulse, pending interrupt level and mask bit.
  assumes the bench calls its tasks right after a rising pclk edge.
*/
`timescale 1ns/1ps
module pmc_cpu_model (
  // clock
  input wire logic pclk,
  // requests toward the controller
  output logic sleep_exec,
  output logic irq_pending,
  output logic cpu_imask
);
  // ==========================================================
  // idle levels at time zero
  initial begin
    sleep_exec = 1'b0;
    irq_pending = 1'b0;
    cpu_imask = 1'b0;
  end

  // ==========================================================
  // one-cycle pulse, as the cpu gives on a sleep instruction
  task automatic fire();
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask : fire

  // enabled interrupt pending, held until the bench drops it
  task automatic irq(input logic v);
    irq_pending <= v;
  endtask : irq

  // cpu mask bit, 1 keeps any request from waking the core
  task automatic mask(input logic v);
    cpu_imask <= v;
  endtask : mask
endmodule : pmc_cpu_model

// [test/power_mode_controller_tb.sv]
/*
  self-checking bench for the power mode controller: apb tasks,
  sleep, wake and direct-switch sequences with expected values.
  assumes pmc_pkg and the controller are compiled before it.
*/
`timescale 1ns/1ps
module power_mode_controller_tb;
  import pmc_pkg::*;
  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, res_pin_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, sleep_exec, irq_pending, cpu_imask;
  logic cpu_halt, low_speed_run, direct_done;
  logic serial_two_clk_en, interval_clk_en, multi_timer_clk_en;
  logic pulse_width_clk_en, cmp_timer_rst, serial_one_rst;
  logic serial_two_rst, converter_rst, rtc_run, wdt_run;
  logic multi_timer_sub_tick, ext_osc_en, sub_osc_en, port_hiz;
  logic chip_reset;
  int bad_count, comparisons, n_wait, cycles, ticks;

  // ==========================================================
  // design, shortened subclock divider, and cpu model
  pmc_power_mode_controller #(.SUB_DIV(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .res_pin_n(res_pin_n),
    .sleep_exec(sleep_exec), .irq_pending(irq_pending),
    .cpu_imask(cpu_imask), .cpu_halt(cpu_halt),
    .low_speed_run(low_speed_run), .direct_done(direct_done),
    .serial_two_clk_en(serial_two_clk_en),
    .interval_clk_en(interval_clk_en),
    .multi_timer_clk_en(multi_timer_clk_en),
    .pulse_width_clk_en(pulse_width_clk_en),
    .cmp_timer_rst(cmp_timer_rst), .serial_one_rst(serial_one_rst),
    .serial_two_rst(serial_two_rst), .converter_rst(converter_rst),
    .rtc_run(rtc_run), .wdt_run(wdt_run),
    .multi_timer_sub_tick(multi_timer_sub_tick),
    .ext_osc_en(ext_osc_en), .sub_osc_en(sub_osc_en),
    .port_hiz(port_hiz), .chip_reset(chip_reset));
  pmc_cpu_model u_cpu (.pclk(pclk), .sleep_exec(sleep_exec),
    .irq_pending(irq_pending), .cpu_imask(cpu_imask));

  // clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      conclude();
    end
  end

  // ==========================================================
  // compare and report
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // one apb transfer; result in q and e, one idle cycle after
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    chk("pready_wait", n, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // raise an interrupt and count edges until the core runs
  task automatic wake();
    n_wait = 0;
    u_cpu.irq(1'b1);
    do begin
      @(posedge pclk);
      n_wait++;
    end while (cpu_halt !== 1'b0 && n_wait < 300);
    u_cpu.irq(1'b0);
    @(posedge pclk);
  endtask : wake

  // set control, sleep, and watch a direct switch for 4 cycles
  task automatic direct(input logic [31:0] c, input logic ls);
    int h, d;
    h = 0;
    d = 0;
    apb(1'b1, PMC_OFF_MODE_CTL, c);
    u_cpu.fire();
    repeat (4) begin
      @(posedge pclk);
      h += (cpu_halt !== 1'b0);
      d += (direct_done === 1'b1);
    end
    chk("direct_halt", h, 0);
    chk("direct_done", d, 1);
    chk("ls_run", low_speed_run, ls);
  endtask : direct

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    res_pin_n = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and gating bits
    apb(1'b0, PMC_OFF_GATE2, 32'h0);
    chk("gate_reset", q, 32'h0);
    apb(1'b1, PMC_OFF_GATE2, 32'hFF);
    apb(1'b0, PMC_OFF_GATE2, 32'h0);
    chk("gate_rsvd", q, 32'h93);
    chk("clk_en", {serial_two_clk_en, interval_clk_en,
      multi_timer_clk_en, pulse_width_clk_en}, 4'h0);
    chk("s2_rst", serial_two_rst, 1'b1);
    apb(1'b1, PMC_OFF_GATE2, 32'h12);
    chk("clk_en", {serial_two_clk_en, interval_clk_en,
      multi_timer_clk_en, pulse_width_clk_en}, 4'h9);
    apb(1'b1, PMC_OFF_GATE2, 32'h01);
    chk("clk_en", {serial_two_clk_en, interval_clk_en,
      multi_timer_clk_en, pulse_width_clk_en}, 4'hE);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", e, 1'b1);
    // sleep, masked request, then wake to high-speed run
    apb(1'b1, PMC_OFF_MODE_CTL, 32'h0);
    u_cpu.fire();
    @(posedge pclk);
    chk("halt", cpu_halt, 1'b1);
    apb(1'b0, PMC_OFF_STATUS, 32'h0);
    chk("sleep_mode", q, 32'h3);
    u_cpu.mask(1'b1);
    u_cpu.irq(1'b1);
    repeat (10) @(posedge pclk);
    chk("masked", cpu_halt, 1'b1);
    u_cpu.mask(1'b0);
    wake();
    chk("woke", cpu_halt, 1'b0);
    chk("hs_run", low_speed_run, 1'b0);
    // standby with wake wait select 1
    apb(1'b1, PMC_OFF_MODE_CTL, 32'h12);
    u_cpu.fire();
    @(posedge pclk);
    chk("hiz", port_hiz, 1'b1);
    chk("osc_off", ext_osc_en, 1'b0);
    apb(1'b0, PMC_OFF_STATUS, 32'h0);
    chk("stby_mode", q, 32'h5);
    wake();
    chk("wait", n_wait >= 32 && n_wait <= 36, 1'b1);
    chk("hiz_off", {port_hiz, low_speed_run}, 2'h0);
    // sleep waking to low-speed run, then the low-power states
    apb(1'b1, PMC_OFF_MODE_CTL, 32'h8);
    u_cpu.fire();
    wake();
    chk("ls_run", low_speed_run, 1'b1);
    chk("osc", {ext_osc_en, sub_osc_en}, 2'h1);
    chk("unit_rst", {cmp_timer_rst, serial_one_rst, serial_two_rst,
      converter_rst}, 4'hF);
    chk("keep", {rtc_run, wdt_run}, 2'h0);
    apb(1'b1, PMC_OFF_MODE_CTL, 32'h708);
    chk("run", {rtc_run, wdt_run}, 2'h3);
    ticks = 0;
    repeat (32) begin
      @(posedge pclk);
      ticks += (multi_timer_sub_tick === 1'b1);
    end
    chk("sub_ticks", ticks, 8);
    // direct switches: ls to ls, ls to hs, hs to hs, hs to ls
    direct(32'hF, 1'b1);
    direct(32'h1, 1'b0);
    direct(32'h1, 1'b0);
    direct(32'h9, 1'b1);
    // subsleep from low-speed run, wake to high-speed run
    apb(1'b1, PMC_OFF_MODE_CTL, 32'h4);
    u_cpu.fire();
    @(posedge pclk);
    chk("sub_rst", {cmp_timer_rst, converter_rst}, 2'h3);
    apb(1'b0, PMC_OFF_STATUS, 32'h0);
    chk("subsleep", q, 32'h4);
    wake();
    chk("hs_rst", {cmp_timer_rst, serial_one_rst, low_speed_run},
      3'h0);
    // external reset pin clears mode and registers
    res_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("pin_reset", {chip_reset, cpu_halt}, 2'h3);
    res_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, PMC_OFF_GATE2, 32'h0);
    chk("gate_clr", q, 32'h0);
    apb(1'b0, PMC_OFF_STATUS, 32'h0);
    chk("hs_after", q, 32'h1);
    // mid-run power-on reset clears the gate register
    apb(1'b1, PMC_OFF_GATE2, 32'h80);
    chk("s2_off", serial_two_clk_en, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("por_mode", {chip_reset, serial_two_clk_en}, 2'h3);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PMC_OFF_GATE2, 32'h0);
    chk("por_gate", q, 32'h0);
    conclude();
  end
endmodule : power_mode_controller_tb
